/* File: design/fspc_pkg.sv */
package fspc_pkg;

  // Clock and timing.
  localparam int unsigned CLK_PERIOD_PS           = 25000;
  localparam int unsigned PROTECT_ASSERT_DELAY_NS = 1000;
  localparam int unsigned PROTECT_RELEASE_DELAY_NS = 1000;
  localparam int unsigned PROTECT_ASSERT_CYC  = (PROTECT_ASSERT_DELAY_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned PROTECT_RELEASE_CYC = (PROTECT_RELEASE_DELAY_NS * 1000) / CLK_PERIOD_PS;
  // Cycles spent outside the stability counter: two sync stages, the filter output, mode and output flops.
  localparam int unsigned WP_PIPE_CYC = 5;
  localparam int unsigned WP_MIN_CYC  = (PROTECT_ASSERT_CYC < PROTECT_RELEASE_CYC) ?
                                        PROTECT_ASSERT_CYC : PROTECT_RELEASE_CYC;
  localparam int unsigned WP_FILTER_CYC = (WP_MIN_CYC > WP_PIPE_CYC + 1) ? WP_MIN_CYC - WP_PIPE_CYC : 1;

  // Command bytes.
  localparam logic [7:0] OPC_PREFIX_0 = 8'h3D;
  localparam logic [7:0] OPC_PREFIX_1 = 8'h2A;
  localparam logic [7:0] OPC_PREFIX_2 = 8'h7F;
  localparam logic [7:0] OPC_ENABLE   = 8'hA9;
  localparam logic [7:0] OPC_DISABLE  = 8'h9A;
  localparam int unsigned CMD_BYTES   = 4;

  // Protection register layout.
  localparam int unsigned SECTOR_COUNT  = 32;
  localparam int unsigned SECTOR_W      = 5;
  localparam logic [7:0]  SPR_PROTECTED = 8'hFF;
  localparam logic [7:0]  SPR_UNPROT    = 8'h00;
  localparam logic [7:0]  SPR_RESET     = 8'h00;
  localparam int unsigned SEC0A_LSB     = 6;
  localparam int unsigned SEC0B_LSB     = 4;

  // Reset values.
  localparam logic WP_N_RESET = 1'b1;

  typedef enum logic [3:0] {
    PM_OFF  = 4'b0001,
    PM_SW   = 4'b0010,
    PM_HW   = 4'b0100,
    PM_LOCK = 4'b1000
  } fspc_mode_e;

  typedef struct packed {
    logic enable;
    logic disarm;
  } fspc_cmd_s;

  typedef struct packed {
    logic                valid;
    logic [SECTOR_W-1:0] sector;
    logic                sub0b;
  } fspc_req_s;

  typedef struct packed {
    logic                valid;
    logic [SECTOR_W-1:0] index;
    logic [7:0]          data;
  } fspc_spr_wr_s;

endpackage

/* File: design/fspc_spi_cmd_decode.sv */
`timescale 1ns/1ps
module fspc_spi_cmd_decode
  import fspc_pkg::*;
(
  input  wire logic            sys_clk_i,
  input  wire logic            reset_i,
  input  wire logic            spi_sck_i,
  input  wire logic            spi_cs_n_i,
  input  wire logic            spi_mosi_i,
  output fspc_pkg::fspc_cmd_s  cmd_o
);
  import fspc_pkg::*;

  logic       sck_prev;
  logic       cs_n_prev;
  logic [7:0] shift;
  logic [2:0] bit_cnt;
  logic [2:0] byte_cnt;
  logic [7:0] cmd_byte [CMD_BYTES];
  logic       prefix_ok;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sck_prev  <= 1'b0;
      cs_n_prev <= 1'b1;
    end else begin
      sck_prev  <= spi_sck_i;
      cs_n_prev <= spi_cs_n_i;
    end
  end

  // Mode 0 and mode 3 both sample data on the rising clock edge.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || spi_cs_n_i) begin
      shift    <= 8'h00;
      bit_cnt  <= 3'd0;
      byte_cnt <= 3'd0;
    end else if (spi_sck_i && !sck_prev) begin
      shift   <= {shift[6:0], spi_mosi_i};
      bit_cnt <= bit_cnt + 3'd1;
      if (bit_cnt == 3'd7 && byte_cnt <= 3'(CMD_BYTES)) begin
        byte_cnt <= byte_cnt + 3'd1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < CMD_BYTES; i++) begin
        cmd_byte[i] <= 8'h00;
      end
    end else if (!spi_cs_n_i && spi_sck_i && !sck_prev && bit_cnt == 3'd7 && byte_cnt < 3'(CMD_BYTES)) begin
      cmd_byte[byte_cnt[1:0]] <= {shift[6:0], spi_mosi_i};
    end
  end

  assign prefix_ok = cmd_byte[0] == OPC_PREFIX_0 && cmd_byte[1] == OPC_PREFIX_1 && cmd_byte[2] == OPC_PREFIX_2;

  // A command counts only if exactly four whole bytes were framed before chip select rose.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cmd_o <= '0;
    end else begin
      cmd_o <= '0;
      if (spi_cs_n_i && !cs_n_prev && byte_cnt == 3'(CMD_BYTES) && bit_cnt == 3'd0 && prefix_ok) begin
        cmd_o.enable  <= cmd_byte[3] == OPC_ENABLE;
        cmd_o.disarm  <= cmd_byte[3] == OPC_DISABLE;
      end
    end
  end

endmodule

/* File: design/fspc_wp_filter.sv */
`timescale 1ns/1ps
module fspc_wp_filter
  import fspc_pkg::*;
#(
  parameter int unsigned FILTER_CYC = fspc_pkg::WP_FILTER_CYC
) (
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  input  wire logic wp_n_i,
  output logic      wp_n_o
);
  import fspc_pkg::*;

  localparam int unsigned CNT_W = $clog2(FILTER_CYC + 1);

  logic             sync_0;
  logic             sync_1;
  logic [CNT_W-1:0] stable_cnt;

  // Both stages rest at the released level, so an idle pin never protects.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sync_0 <= WP_N_RESET;
      sync_1 <= WP_N_RESET;
    end else begin
      sync_0 <= wp_n_i;
      sync_1 <= sync_0;
    end
  end

  // The filtered level follows only after the input has held a new level for FILTER_CYC cycles.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      stable_cnt <= '0;
      wp_n_o     <= WP_N_RESET;
    end else if (sync_1 == wp_n_o) begin
      stable_cnt <= '0;
    end else if (stable_cnt == CNT_W'(FILTER_CYC - 1)) begin
      stable_cnt <= '0;
      wp_n_o     <= sync_1;
    end else begin
      stable_cnt <= stable_cnt + CNT_W'(1);
    end
  end

endmodule

/* File: design/fspc_sector_protect.sv */
`timescale 1ns/1ps
// Overview of operation
// - Bytes 3D 2A 7F A9 in one frame arm software protection.
// - Command acts only when chip select rises right after the fourth byte.
// - Bytes 3D 2A 7F 9A clear software protection on chip select release.
// - Software protection is volatile and starts off after power-up.
// - A floating protect pin reads as released; the design only resets its sync stages to released, wp_n_i has no pull-up.
// - Pin asserted blocks marked sectors and the protection register itself.
// - Pin assertion turns protection on within the assert delay.
// - Pin release turns protection off within the release delay unless enabled.
// - An enable before or during assertion keeps protection after release.
// - Disable command is ignored while the pin is asserted.
// - The pin only adds protection, never removes software protection.
// - The protect input is filtered against short glitches.
// - Status shows protection enabled by software or pin.
// - Only sectors marked in the protection register are blocked.
// - One byte per sector for 32 sectors; FFh protected, 00h unprotected.
module fspc_sector_protect
  import fspc_pkg::*;
#(
  parameter int unsigned SECTORS    = fspc_pkg::SECTOR_COUNT,
  parameter int unsigned FILTER_CYC = fspc_pkg::WP_FILTER_CYC
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   reset_i,
  input  wire logic                   spi_sck_i,
  input  wire logic                   spi_cs_n_i,
  input  wire logic                   spi_mosi_i,
  input  wire logic                   wp_n_i,
  input  fspc_pkg::fspc_req_s         req_i,
  input  fspc_pkg::fspc_spr_wr_s      spr_wr_i,
  input  wire logic [fspc_pkg::SECTOR_W-1:0] spr_rd_index_i,
  output logic                        prot_enabled_o,
  output logic                        sw_enabled_o,
  output logic                        wp_active_o,
  output logic                        req_start_o,
  output logic                        req_reject_o,
  output logic                        spr_wr_done_o,
  output logic                        spr_wr_reject_o,
  output logic [7:0]                  spr_rd_data_o
);
  import fspc_pkg::*;

  fspc_cmd_s  cmd;
  logic       wp_n_filt;
  logic       wp_asserted;
  fspc_mode_e mode;
  fspc_mode_e next_mode;
  logic       prot_active;
  logic [7:0] spr_mem [SECTORS];
  logic [7:0] req_byte;
  logic       req_marked;

  // Decides whether a protection byte marks the addressed sector.
  function automatic logic sector_marked(input logic [7:0] value, input logic [SECTOR_W-1:0] sector,
                                         input logic sub0b);
    logic hit;
    hit = 1'b0;
    if (sector == '0) begin
      hit = sub0b ? (value[SEC0B_LSB +: 2] == 2'b11) : (value[SEC0A_LSB +: 2] == 2'b11);
    end else begin
      hit = value == SPR_PROTECTED;
    end
    return hit;
  endfunction

  fspc_spi_cmd_decode u_cmd (
    .sys_clk_i  (sys_clk_i),
    .reset_i    (reset_i),
    .spi_sck_i  (spi_sck_i),
    .spi_cs_n_i (spi_cs_n_i),
    .spi_mosi_i (spi_mosi_i),
    .cmd_o      (cmd)
  );

  fspc_wp_filter #(
    .FILTER_CYC (FILTER_CYC)
  ) u_wp (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .wp_n_i    (wp_n_i),
    .wp_n_o    (wp_n_filt)
  );

  assign wp_asserted = !wp_n_filt;

  // Mode encodes the software enable together with the pin level.
  always_comb begin
    next_mode = mode;
    case (mode)
      PM_OFF: begin
        if (wp_asserted) begin
          next_mode = cmd.enable ? PM_LOCK : PM_HW;
        end else if (cmd.enable) begin
          next_mode = PM_SW;
        end
      end
      PM_SW: begin
        if (wp_asserted) begin
          next_mode = PM_LOCK;
        end else if (cmd.disarm) begin
          next_mode = PM_OFF;
        end
      end
      PM_HW: begin
        if (!wp_asserted) begin
          next_mode = cmd.enable ? PM_SW : PM_OFF;
        end else if (cmd.enable) begin
          next_mode = PM_LOCK;
        end
      end
      PM_LOCK: begin
        if (!wp_asserted) begin
          next_mode = PM_SW;
        end
        // A disable here is dropped on purpose.
      end
      default: begin
        next_mode = PM_OFF;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      mode <= PM_OFF;
    end else begin
      mode <= next_mode;
    end
  end

  assign prot_active = mode != PM_OFF;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      prot_enabled_o <= 1'b0;
      sw_enabled_o   <= 1'b0;
      wp_active_o    <= 1'b0;
    end else begin
      prot_enabled_o <= prot_active;
      sw_enabled_o   <= mode == PM_SW || mode == PM_LOCK;
      wp_active_o    <= mode == PM_HW || mode == PM_LOCK;
    end
  end

  // Protection register: writes are refused while the pin is asserted.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < SECTORS; i++) begin
        spr_mem[i] <= SPR_RESET;
      end
    end else if (spr_wr_i.valid && !wp_asserted) begin
      spr_mem[spr_wr_i.index] <= spr_wr_i.data;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      spr_wr_done_o   <= 1'b0;
      spr_wr_reject_o <= 1'b0;
      spr_rd_data_o   <= SPR_UNPROT;
    end else begin
      spr_wr_done_o   <= spr_wr_i.valid && !wp_asserted;
      spr_wr_reject_o <= spr_wr_i.valid && wp_asserted;
      spr_rd_data_o   <= spr_mem[spr_rd_index_i];
    end
  end

  assign req_byte   = spr_mem[req_i.sector];
  assign req_marked = sector_marked(req_byte, req_i.sector, req_i.sub0b);

  // Each request is answered one cycle later by exactly one of start or reject.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      req_start_o  <= 1'b0;
      req_reject_o <= 1'b0;
    end else begin
      req_start_o  <= req_i.valid && !(prot_active && req_marked);
      req_reject_o <= req_i.valid && prot_active && req_marked;
    end
  end

endmodule

/* File: dv/fspc_checker.sv */
`timescale 1ns/1ps
module fspc_checker
  import fspc_pkg::*;
#(
  parameter int unsigned FILTER_CYC = 3
) (
  input  wire logic           sys_clk_i,
  input  wire logic           reset_i,
  input  wire logic           spi_cs_n_i,
  input  wire logic           wp_n_i,
  input  fspc_pkg::fspc_req_s req_i,
  input  fspc_pkg::fspc_spr_wr_s spr_wr_i,
  input  wire logic [4:0]     spr_rd_index_i,
  input  wire logic           prot_enabled_o,
  input  wire logic           sw_enabled_o,
  input  wire logic           wp_active_o,
  input  wire logic           req_start_o,
  input  wire logic           req_reject_o,
  input  wire logic           spr_wr_done_o,
  input  wire logic           spr_wr_reject_o,
  input  wire logic [7:0]     spr_rd_data_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  // Cycles the raw pin has held low or high, saturating.
  logic [7:0] lo_cnt;
  logic [7:0] hi_cnt;
  always_ff @(posedge sys_clk_i) begin
    lo_cnt <= (reset_i || wp_n_i) ? 8'h00 : lo_cnt + {7'h00, lo_cnt != 8'hFF};
    hi_cnt <= (reset_i || !wp_n_i) ? 8'h00 : hi_cnt + {7'h00, hi_cnt != 8'hFF};
  end

  req_resp_a: assert property (req_i.valid |=> req_start_o != req_reject_o)
    else $error("request not answered once");
  rej_prot_a: assert property (req_reject_o |-> prot_enabled_o || $past(prot_enabled_o))
    else $error("reject without protection");
  prot_src_a: assert property (prot_enabled_o == (sw_enabled_o || wp_active_o))
    else $error("protection status wrong");
  spr_resp_a: assert property (spr_wr_i.valid |=> spr_wr_done_o != spr_wr_reject_o)
    else $error("register write not answered");
  spr_rd_a: assert property ((spr_wr_i.valid && spr_wr_i.index == spr_rd_index_i) ##1
    (spr_wr_done_o && $stable(spr_rd_index_i)) |=> spr_rd_data_o == $past(spr_wr_i.data, 2))
    else $error("register byte not stored");
  wp_on_a: assert property (lo_cnt >= FILTER_CYC + 5 |-> wp_active_o && prot_enabled_o)
    else $error("pin assert too slow");
  wp_off_a: assert property (hi_cnt >= FILTER_CYC + 5 |-> !wp_active_o)
    else $error("pin release too slow");
  sw_cmd_a: assert property ($changed(sw_enabled_o) |-> $past(spi_cs_n_i, 3) && !$past(spi_cs_n_i, 5))
    else $error("enable changed off frame end");
endmodule

bind fspc_sector_protect fspc_checker #(.FILTER_CYC(FILTER_CYC)) fspc_checker_i (.sys_clk_i, .reset_i,
  .spi_cs_n_i, .wp_n_i, .req_i, .spr_wr_i, .spr_rd_index_i, .prot_enabled_o, .sw_enabled_o, .wp_active_o,
  .req_start_o, .req_reject_o, .spr_wr_done_o, .spr_wr_reject_o, .spr_rd_data_o);

/* File: dv/fspc_spi_host.sv */
`timescale 1ns/1ps
module fspc_spi_host (
  input  wire logic        sys_clk_i,
  input  wire logic        start_i,
  input  wire logic [31:0] word_i,
  input  wire logic [5:0]  nbits_i,
  output logic             sck_o = 1'b0,
  output logic             cs_n_o = 1'b1,
  output logic             mosi_o = 1'b0,
  output logic             busy_o = 1'b0
);
  logic [31:0] sh;
  logic [5:0]  left;
  logic [1:0]  ph;
  // MSB first, clock high and low two cycles each; data toggles while released.
  always @(posedge sys_clk_i) begin
    if (!busy_o) begin
      mosi_o <= ~mosi_o;
      if (start_i) begin
        busy_o <= 1'b1;
        cs_n_o <= 1'b0;
        sh     <= word_i;
        left   <= nbits_i;
        ph     <= 2'h0;
      end
    end else if (left == 6'h00) begin
      cs_n_o <= 1'b1;
      busy_o <= 1'b0;
    end else begin
      ph <= ph + 2'h1;
      case (ph)
        2'h0: mosi_o <= sh[31];
        2'h1: sck_o <= 1'b1;
        2'h3: begin
          sck_o <= 1'b0;
          sh    <= sh << 1;
          left  <= left - 6'h01;
        end
        default: ;
      endcase
    end
  end
endmodule

/* File: dv/fspc_sector_protect_tb.sv */
`timescale 1ns/1ps
module fspc_sector_protect_tb;
  import fspc_pkg::*;
  localparam int unsigned FILT = 3;
  logic         sys_clk_i, reset_i, wp_n_i, start, busy, sck, cs_n, mosi;
  logic         prot, sw, wpa, rs, rj, wd, wj;
  logic [31:0]  word, v;
  logic [5:0]   nbits;
  logic [4:0]   rd_idx;
  logic [7:0]   rd;
  fspc_req_s    req;
  fspc_spr_wr_s wr;
  int           errors, tests_run, spr_m[32];
  bit           sw_m, wp_m;

  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  fspc_sector_protect #(.FILTER_CYC(FILT)) fspc_sector_protect_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .spi_sck_i(sck), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .wp_n_i(wp_n_i), .req_i(req), .spr_wr_i(wr),
    .spr_rd_index_i(rd_idx), .prot_enabled_o(prot), .sw_enabled_o(sw), .wp_active_o(wpa), .req_start_o(rs),
    .req_reject_o(rj), .spr_wr_done_o(wd), .spr_wr_reject_o(wj), .spr_rd_data_o(rd));
  fspc_spi_host fspc_spi_host_i (.sys_clk_i(sys_clk_i), .start_i(start), .word_i(word), .nbits_i(nbits),
    .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi), .busy_o(busy));

  task automatic end_sim();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp(logic [7:0] got, logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic st();
    @(negedge sys_clk_i);
    cmp({5'h00, prot, sw, wpa}, {5'h00, sw_m | wp_m, sw_m, wp_m});
  endtask

  task automatic spi(logic [31:0] w, logic [5:0] n);
    int k;
    @(posedge sys_clk_i);
    word  <= w;
    nbits <= n;
    start <= 1'b1;
    @(posedge sys_clk_i);
    start <= 1'b0;
    @(negedge sys_clk_i);
    for (k = 0; k < 400 && busy; k++) @(negedge sys_clk_i);
    if (k == 400) begin
      errors++;
      $display("MISMATCH %0t spi frame timeout", $time);
      end_sim();
    end
    repeat (6) @(negedge sys_clk_i);
  endtask

  task automatic req_all();
    bit hit;
    for (int s = 0; s < 64; s++) begin
      @(posedge sys_clk_i);
      req <= {1'b1, s[4:0], s[5]};
      @(posedge sys_clk_i);
      req.valid <= 1'b0;
      @(negedge sys_clk_i);
      hit = (s % 32 == 0) ? ((spr_m[0] >> (s >= 32 ? 4 : 6)) & 3) == 3 : spr_m[s % 32] == 255;
      hit = hit && (sw_m || wp_m);
      cmp({6'h00, rs, rj}, {6'h00, !hit, hit});
    end
  endtask

  task automatic spr(int i, logic [7:0] d);
    @(posedge sys_clk_i);
    wr     <= {1'b1, i[4:0], d};
    rd_idx <= i[4:0];
    @(posedge sys_clk_i);
    wr.valid <= 1'b0;
    @(negedge sys_clk_i);
    cmp({6'h00, wd, wj}, {6'h00, !wp_m, wp_m});
    if (!wp_m) spr_m[i] = d;
    @(negedge sys_clk_i);
    cmp(rd, spr_m[i][7:0]);
  endtask

  task automatic pin(logic lvl);
    @(posedge sys_clk_i);
    wp_n_i <= lvl;
    repeat (FILT + 6) @(posedge sys_clk_i);
    wp_m = !lvl;
    st();
  endtask

  initial begin
    {reset_i, wp_n_i, start, word, nbits, req, wr, rd_idx} = '0;
    reset_i = 1'b1;
    wp_n_i  = 1'b1;
    void'($urandom(32'h4AFCD80B));
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    st();
    for (int i = 0; i < 32; i++) begin
      v = $urandom;
      spr(i, i == 0 ? {v[1], v[1], v[0], v[0], v[7:4]} : {8{v[0]}});
    end
    req_all();
    spi(32'h3D2A7FA9, 6'h20);
    sw_m = 1'b1;
    req_all();
    spi(32'h3D2A7F00, 6'h18);
    spi(32'h3D2B7F9A, 6'h20);
    st();
    spi(32'h3D2A7F9A, 6'h20);
    sw_m = 1'b0;
    st();
    @(posedge sys_clk_i);
    wp_n_i <= 1'b0;
    repeat (FILT - 1) @(posedge sys_clk_i);
    wp_n_i <= 1'b1;
    repeat (FILT + 6) @(posedge sys_clk_i);
    st();
    pin(1'b0);
    req_all();
    spr(1, ~spr_m[1][7:0]);
    spi(32'h3D2A7FA9, 6'h20);
    sw_m = 1'b1;
    spi(32'h3D2A7F9A, 6'h20);
    st();
    pin(1'b1);
    spi(32'h3D2A7F9A, 6'h20);
    sw_m = 1'b0;
    st();
    pin(1'b0);
    pin(1'b1);
    spi(32'h3D2A7FA9, 6'h20);
    sw_m = 1'b1;
    pin(1'b0);
    @(posedge sys_clk_i);
    wp_n_i <= 1'b1;
    repeat (FILT - 1) @(posedge sys_clk_i);
    wp_n_i <= 1'b0;
    repeat (FILT + 6) @(posedge sys_clk_i);
    st();
    pin(1'b1);
    spi(32'h3D2A7F9A, 6'h20);
    sw_m = 1'b0;
    st();
    end_sim();
  end
endmodule
